/* lcpg_pkg.sv */
// lcpg_pkg: shared constants and types for the lookup-table cells and pattern generator.
// assumes: one clock (aclk), configuration image loaded over an axi4-lite slave.
`default_nettype none

package lcpg_pkg;

	// configuration image covers absolute bits 592..793
	localparam int CFG_BASE_BIT    = 592;
	localparam int CFG_TOP_BIT     = 793;
	localparam int CFG_BITS        = CFG_TOP_BIT - CFG_BASE_BIT + 1;
	localparam int CFG_WORDS       = (CFG_BITS + 31) / 32;

	// three-input table field layout
	localparam int T3_COUNT        = 16;
	localparam int T3_WIDTH        = 8;
	localparam int T3_LOW_BASE     = 592;
	localparam int T3_HIGH_FIRST   = 8;
	localparam int T3_HIGH_BASE    = 714;

	// four-input tables and pattern generator fields
	localparam int QUAD_BITS       = 16;
	localparam int COMBO_DATA_LSB  = 656;
	localparam int SERIAL_PATTERN_GENERATOR_COUNT_LSB  = 672;
	localparam int SERIAL_PATTERN_GENERATOR_COUNT_BITS = 4;
	localparam int SERIAL_PATTERN_GENERATOR_MODE_BIT   = 676;
	localparam int M1Q_DATA_LSB    = 778;
	localparam logic MODE_TABLE    = 1'h0;
	localparam logic MODE_PATTERN  = 1'h1;

	// register map, byte addresses on a 32-bit axi4-lite bus
	localparam int ADDR_W          = 5;
	localparam logic [2:0] CFG_LAST_INDEX = 3'h6;
	localparam logic [2:0] STATUS_INDEX   = 3'h7;
	localparam logic [4:0] CFG_WORD0_OFFSET = 5'h00;
	localparam logic [4:0] STATUS_OFFSET  = 5'h1c;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;

	// reset values
	localparam logic [CFG_BITS-1:0] CFG_RESET = '0;

	typedef enum logic {LCPG_WR_COLLECT, LCPG_WR_RESP} lcpg_wr_state_t;
	typedef enum logic {LCPG_RD_IDLE, LCPG_RD_RESP} lcpg_rd_state_t;

	typedef struct packed {
		logic [CFG_BITS-1:0]        cfg;
		lcpg_wr_state_t             wr_state;
		logic                       aw_have;
		logic [2:0]                 aw_idx;
		logic                       w_have;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic [1:0]                 bresp;
		lcpg_rd_state_t             rd_state;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic                       clk_sync1;
		logic                       clk_sync2;
		logic                       clk_prev;
		logic [SERIAL_PATTERN_GENERATOR_COUNT_BITS-1:0] idx;
		logic                       pat_bit;
	} lcpg_state_t;

	// position of an absolute configuration bit inside the image
	function automatic int cfg_pos(input int abs_bit);
		return abs_bit - CFG_BASE_BIT;
	endfunction : cfg_pos

	// absolute lowest bit of three-input table t
	function automatic int t3_base(input int t);
		return (t < T3_HIGH_FIRST) ? T3_LOW_BASE + T3_WIDTH * t
			: T3_HIGH_BASE + T3_WIDTH * (t - T3_HIGH_FIRST);
	endfunction : t3_base

	// one 32-bit word of the image, zero above the top bit
	function automatic logic [31:0] cfg_word(input logic [CFG_BITS-1:0] c, input int k);
		logic [CFG_WORDS*32-1:0] img;
		img = '0;
		img[CFG_BITS-1:0] = c;
		return img[k*32 +: 32];
	endfunction : cfg_word

endpackage : lcpg_pkg

`default_nettype wire

/* lcpg_table.sv */
// lcpg_table: one n-input lookup cell, output = function bit indexed by the inputs.
// assumes: function bits stay steady while the cell is in use; no clock, no state.
`default_nettype none

module lcpg_table #(
	parameter int N = 3
) (
	input  wire logic [(1<<N)-1:0] func_bits,
	input  wire logic [N-1:0]      sel_in,
	output logic                   table_out
);

	// input n-1 is the msb of the index, bit 0 of func_bits answers index zero
	assign table_out = func_bits[sel_in];

endmodule : lcpg_table

`default_nettype wire

/* lcpg_top.sv */
// lcpg_top: sixteen 3-input tables, one 4-input table on matrix 1 and a combination
// macrocell (4-input table on matrix 0 or serial pattern generator).
// assumes: table inputs come from routing logic; pattern clock is a routed signal that is
// sampled on aclk; the configuration image is loaded over axi4-lite.
`default_nettype none

module lcpg_top #(
	parameter int T3_NUM = lcpg_pkg::T3_COUNT
) (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite slave
	input  wire logic [lcpg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [lcpg_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// three-input tables, cell t uses tri_table_in[3t+2:3t]
	input  wire logic [3*T3_NUM-1:0]         tri_table_in,
	output logic [T3_NUM-1:0]                tri_table_out,
	// matrix-1 quad table
	input  wire logic [3:0]                  matrix1_quad_table_in,
	output logic                             matrix1_quad_table_out,
	// combination macrocell on matrix 0
	input  wire logic [3:0]                  combo_quad_table_in,
	input  wire logic                        serial_pattern_generator_clk,
	output logic                             combo_quad_table_out
);

	lcpg_pkg::lcpg_state_t st_q;
	lcpg_pkg::lcpg_state_t st_d;

	localparam lcpg_pkg::lcpg_state_t ST_RESET = '{
		cfg:       lcpg_pkg::CFG_RESET,
		wr_state:  lcpg_pkg::LCPG_WR_COLLECT,
		aw_have:   1'h0,
		aw_idx:    3'h0,
		w_have:    1'h0,
		wdata:     32'h0,
		wstrb:     4'h0,
		bresp:     lcpg_pkg::RESP_OKAY,
		rd_state:  lcpg_pkg::LCPG_RD_IDLE,
		rdata:     32'h0,
		rresp:     lcpg_pkg::RESP_OKAY,
		clk_sync1: 1'h0,
		clk_sync2: 1'h0,
		clk_prev:  1'h0,
		idx:       4'h0,
		pat_bit:   1'h0
	};

	// decoded configuration fields
	logic [lcpg_pkg::QUAD_BITS-1:0]       combo_data;
	logic [lcpg_pkg::QUAD_BITS-1:0]       m1q_data;
	logic [lcpg_pkg::SERIAL_PATTERN_GENERATOR_COUNT_BITS-1:0] serial_pattern_generator_count;
	logic                                 serial_pattern_generator_mode;
	logic                                 combo_table_out;

	// field slices of the image; each sits at its absolute bit position
	assign combo_data = st_q.cfg[lcpg_pkg::cfg_pos(lcpg_pkg::COMBO_DATA_LSB) +:
		lcpg_pkg::QUAD_BITS];
	assign m1q_data   = st_q.cfg[lcpg_pkg::cfg_pos(lcpg_pkg::M1Q_DATA_LSB) +:
		lcpg_pkg::QUAD_BITS];
	assign serial_pattern_generator_count = st_q.cfg[lcpg_pkg::cfg_pos(lcpg_pkg::SERIAL_PATTERN_GENERATOR_COUNT_LSB) +:
		lcpg_pkg::SERIAL_PATTERN_GENERATOR_COUNT_BITS];
	assign serial_pattern_generator_mode  = st_q.cfg[lcpg_pkg::cfg_pos(lcpg_pkg::SERIAL_PATTERN_GENERATOR_MODE_BIT)];

	// sixteen three-input cells; output index t pairs with input triple t
	genvar t;
	generate
		for (t = 0; t < T3_NUM; t++) begin : g_tri
			lcpg_table #(
				.N(3)
			) u_tri (
				.func_bits (st_q.cfg[lcpg_pkg::cfg_pos(lcpg_pkg::t3_base(t)) +:
					lcpg_pkg::T3_WIDTH]),
				.sel_in    (tri_table_in[3*t +: 3]),
				.table_out (tri_table_out[t])
			);
		end
	endgenerate

	// matrix-1 quad table: select_input_msb is bit 3, select_input_lsb bit 0
	lcpg_table #(
		.N(4)
	) u_m1q (
		.func_bits (m1q_data),
		.sel_in    (matrix1_quad_table_in),
		.table_out (matrix1_quad_table_out)
	);

	// combination macrocell, table half; always computed, muxed by role below
	lcpg_table #(
		.N(4)
	) u_combo (
		.func_bits (combo_data),
		.sel_in    (combo_quad_table_in),
		.table_out (combo_table_out)
	);

	// one role at a time: table output is combinational, pattern bit is a flop
	assign combo_quad_table_out = (serial_pattern_generator_mode == lcpg_pkg::MODE_PATTERN) ?
		st_q.pat_bit : combo_table_out;

	// bus handshakes straight from state
	assign s_axi_awready = (st_q.wr_state == lcpg_pkg::LCPG_WR_COLLECT) && !st_q.aw_have;
	assign s_axi_wready  = (st_q.wr_state == lcpg_pkg::LCPG_WR_COLLECT) && !st_q.w_have;
	assign s_axi_bvalid  = (st_q.wr_state == lcpg_pkg::LCPG_WR_RESP);
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = (st_q.rd_state == lcpg_pkg::LCPG_RD_IDLE);
	assign s_axi_rvalid  = (st_q.rd_state == lcpg_pkg::LCPG_RD_RESP);
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;

	// next-state logic for bus slave, configuration image and pattern generator
	always_comb begin
		logic                              aw_take;
		logic                              w_take;
		logic                              aw_ok;
		logic                              w_ok;
		logic [2:0]                        widx;
		logic [2:0]                        ridx;
		logic [31:0]                       wd;
		logic [3:0]                        ws;
		logic [lcpg_pkg::CFG_WORDS*32-1:0] img;
		logic                              pclk_rise;
		aw_take   = s_axi_awvalid && s_axi_awready;
		w_take    = s_axi_wvalid && s_axi_wready;
		aw_ok     = st_q.aw_have || aw_take;
		w_ok      = st_q.w_have || w_take;
		widx      = st_q.aw_have ? st_q.aw_idx : s_axi_awaddr[4:2];
		ridx      = s_axi_araddr[4:2];
		wd        = st_q.w_have ? st_q.wdata : s_axi_wdata;
		ws        = st_q.w_have ? st_q.wstrb : s_axi_wstrb;
		img       = '0;
		pclk_rise = st_q.clk_sync2 && !st_q.clk_prev;
		st_d      = st_q;

		// write channel: address and data may arrive in either order
		case (st_q.wr_state)
			lcpg_pkg::LCPG_WR_COLLECT: begin
				if (aw_take) begin
					st_d.aw_have = 1'h1;
					st_d.aw_idx  = s_axi_awaddr[4:2];
				end
				if (w_take) begin
					st_d.w_have = 1'h1;
					st_d.wdata  = s_axi_wdata;
					st_d.wstrb  = s_axi_wstrb;
				end
				if (aw_ok && w_ok) begin
					st_d.aw_have  = 1'h0;
					st_d.w_have   = 1'h0;
					st_d.wr_state = lcpg_pkg::LCPG_WR_RESP;
					if (widx <= lcpg_pkg::CFG_LAST_INDEX) begin
						// byte lanes merge into the image; bits above the top are dropped
						img[lcpg_pkg::CFG_BITS-1:0] = st_q.cfg;
						for (int b = 0; b < 4; b++) begin
							if (ws[b]) begin
								img[32*widx + 8*b +: 8] = wd[8*b +: 8];
							end
						end
						st_d.cfg   = img[lcpg_pkg::CFG_BITS-1:0];
						st_d.bresp = lcpg_pkg::RESP_OKAY;
					end else begin
						// status word is read-only
						st_d.bresp = lcpg_pkg::RESP_SLVERR;
					end
				end
			end
			lcpg_pkg::LCPG_WR_RESP: begin
				if (s_axi_bready) begin
					st_d.wr_state = lcpg_pkg::LCPG_WR_COLLECT;
				end
			end
			default: begin
				st_d.wr_state = lcpg_pkg::LCPG_WR_COLLECT;
			end
		endcase

		// read channel: data registered, one word in flight
		case (st_q.rd_state)
			lcpg_pkg::LCPG_RD_IDLE: begin
				if (s_axi_arvalid) begin
					st_d.rd_state = lcpg_pkg::LCPG_RD_RESP;
					st_d.rresp    = lcpg_pkg::RESP_OKAY;
					if (ridx <= lcpg_pkg::CFG_LAST_INDEX) begin
						st_d.rdata = lcpg_pkg::cfg_word(st_q.cfg, int'(ridx));
					end else begin
						// live state: pattern position, pattern bit, role and the two quad-table outputs
						st_d.rdata = {24'h0, st_q.idx, st_q.pat_bit, serial_pattern_generator_mode,
							combo_quad_table_out, matrix1_quad_table_out};
					end
				end
			end
			lcpg_pkg::LCPG_RD_RESP: begin
				if (s_axi_rready) begin
					st_d.rd_state = lcpg_pkg::LCPG_RD_IDLE;
				end
			end
			default: begin
				st_d.rd_state = lcpg_pkg::LCPG_RD_IDLE;
			end
		endcase

		// pattern clock is a routed signal: two flops, then edge detect on the second
		st_d.clk_sync1 = serial_pattern_generator_clk;
		st_d.clk_sync2 = st_q.clk_sync1;
		st_d.clk_prev  = st_q.clk_sync2;

		// pattern generator; table mode parks it at bit 0 so each run starts there
		if (serial_pattern_generator_mode == lcpg_pkg::MODE_PATTERN) begin
			if (pclk_rise) begin
				// >= also recovers if the count is lowered below the current position
				if (st_q.idx >= serial_pattern_generator_count) begin
					st_d.idx = '0;
				end else begin
					st_d.idx = st_q.idx + 4'h1;
				end
			end
		end else begin
			st_d.idx = '0;
		end
		st_d.pat_bit = combo_data[st_d.idx];
	end

	// single state register, synchronous active-low reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

endmodule : lcpg_top

`default_nettype wire

/* lcpg_top_assertions.sv */
// lcpg_checker: bus handshake and table purity properties on the lcpg_top ports.
// assumes: bound to every lcpg_top, one clock, aresetn low resets.
`default_nettype none

module lcpg_checker #(
	parameter int T3_NUM = 16
) (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic [4:0]            s_axi_awaddr,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [3*T3_NUM-1:0]   tri_table_in,
	input wire logic [T3_NUM-1:0]     tri_table_out,
	input wire logic [3:0]            matrix1_quad_table_in,
	input wire logic                  matrix1_quad_table_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// any write beat may reload the image, so purity is judged only across quiet edges
	sequence s_quiet;
		!(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready);
	endsequence
	sequence s_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	property p_tri_pure;
		s_quiet ##1 $stable(tri_table_in) |-> $stable(tri_table_out);
	endproperty
	a_tri_pure: assert property (p_tri_pure) else $error("table output moved alone");
	property p_quad_own_inputs;
		s_quiet ##1 $stable(matrix1_quad_table_in) |-> $stable(matrix1_quad_table_out);
	endproperty
	a_quad_own_inputs: assert property (p_quad_own_inputs)
		else $error("quad table reacts to foreign inputs");
	property p_b_latency;
		s_both_taken |=> s_axi_bvalid;
	endproperty
	a_b_latency: assert property (p_b_latency) else $error("write answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_latency;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_latency: assert property (p_r_latency) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_status_refused;
		s_axi_awvalid && s_axi_awready && s_axi_awaddr[4:2] == 3'h7
			|-> ##[1:20] s_axi_bvalid && s_axi_bresp == lcpg_pkg::RESP_SLVERR;
	endproperty
	a_status_refused: assert property (p_status_refused) else $error("status write accepted");
	property p_rresp_okay;
		s_axi_rvalid |-> s_axi_rresp == lcpg_pkg::RESP_OKAY;
	endproperty
	a_rresp_okay: assert property (p_rresp_okay) else $error("read response not okay");
	property p_one_write;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_one_write: assert property (p_one_write) else $error("write taken while answering");
	property p_one_read;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_one_read: assert property (p_one_read) else $error("read taken while answering");
endmodule : lcpg_checker

bind lcpg_top lcpg_checker #(.T3_NUM(T3_NUM)) i_chk (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tri_table_in, .tri_table_out,
	.matrix1_quad_table_in, .matrix1_quad_table_out);

`default_nettype wire

/* lcpg_route_model.sv */
// lcpg_route_model: routing-matrix source of the pattern advance signal.
// assumes: fire is a one-cycle request from the bench on aclk.
`default_nettype none

module lcpg_route_model (
	input  wire logic aclk,
	input  wire logic fire,
	output logic      pattern_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hold_q = 3'h0;

	// high four periods, low otherwise: both phases exceed the two-period sampler minimum
	// plain always, since the start value comes from the declaration
	always @(posedge aclk) begin
		if (fire) begin
			hold_q <= 3'h4;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
	end
	assign pattern_clk = (hold_q != 3'h0);
endmodule : lcpg_route_model

`default_nettype wire

/* lcpg_top_test.sv */
// lcpg_top_test: register loads, table truth checks and pattern sequence on lcpg_top.
// assumes: lcpg_route_model drives the pattern pin; bench drives all table inputs.
`default_nettype none

module lcpg_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, pat_clk;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [47:0] tri_in = 48'h0;
	logic [15:0] tri_out;
	logic [3:0] m1_in = 4'h0, combo_in = 4'h0;
	logic m1_out, combo_out;
	logic [815:592] img;
	logic [7:0] gate [6] = '{8'h80, 8'h7f, 8'hfe, 8'h01, 8'h96, 8'h69};
	int fails = 0, n_checks = 0;

	always #12.5 aclk = ~aclk;

	lcpg_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tri_table_in(tri_in), .tri_table_out(tri_out),
		.matrix1_quad_table_in(m1_in), .matrix1_quad_table_out(m1_out),
		.combo_quad_table_in(combo_in), .serial_pattern_generator_clk(pat_clk),
		.combo_quad_table_out(combo_out));
	lcpg_route_model i_route (.aclk, .fire, .pattern_clk(pat_clk));

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk

	task chk_bit(input string what, input logic e, input logic g);
		chk(what, {31'h0, e}, {31'h0, g});
	endtask : chk_bit

	// address and data offered together, each dropped at its own take edge
	task wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_w, w_w;
		aw_w = 1'b1;
		w_w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw_w || w_w) begin
			@(posedge aclk);
			if (aw_w && s_axi_awready === 1'b1) begin
				aw_w = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_w && s_axi_wready === 1'b1) begin
				w_w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		// bready rises only once both halves are in, so back-to-back calls never
		// lower and raise it within one time step
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task rd(input logic [4:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		// rready rises after the address is taken, keeping one assignment per step
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		chk("read resp", 32'(lcpg_pkg::RESP_OKAY), {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
	endtask : rd

	// lowest image bit of three-input cell t
	function automatic int tri_lo(input int t);
		return (t < 7) ? 592 + 8 * t : ((t == 7) ? 648 : 714 + 8 * (t - 8));
	endfunction : tri_lo

	initial begin
		#(25ns * 20000);
		fails++;
		tally_and_finish();
	end

	initial begin
		logic [1:0] r;
		logic [31:0] d;
		int k;
		int t;
		int v;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 8; k++) begin
			rd(5'(4 * k), d);
			chk("reset word", 32'h0, d);
		end
		// ones above bit 793 must be dropped by the slave
		img = '1;
		for (t = 0; t < 16; t++) img[tri_lo(t) +: 8] = gate[t % 6];
		img[793:778] = 16'h6996;
		img[676:656] = {5'h00, 16'hb5c3};
		for (k = 0; k < 7; k++) begin
			wr(5'(4 * k), img[592 + 32 * k +: 32], r);
			chk("write resp", 32'(lcpg_pkg::RESP_OKAY), {30'h0, r});
		end
		img[815:794] = '0;
		wr(lcpg_pkg::STATUS_OFFSET, 32'hffffffff, r);
		chk("status resp", 32'(lcpg_pkg::RESP_SLVERR), {30'h0, r});
		for (k = 0; k < 7; k++) begin
			rd(5'(4 * k), d);
			chk("image word", img[592 + 32 * k +: 32], d);
		end
		for (v = 0; v < 16; v++) begin
			tri_in <= {16{3'(v)}};
			m1_in <= 4'(v);
			combo_in <= 4'(v);
			@(posedge aclk);
			@(posedge aclk);
			for (t = 0; t < 16; t++) chk_bit("tri out", gate[t % 6][v % 8], tri_out[t]);
			chk_bit("m1 out", img[778 + v], m1_out);
			chk_bit("combo out", img[656 + v], combo_out);
		end
		// count 3 gives four bits; data chosen so a wrong wrap point shows
		// table input 2 selects a 0, so only the pattern role can show data bit 0 here
		combo_in <= 4'h2;
		wr(5'h08, {11'h0, 1'b1, 4'h3, 16'hb5c3}, r);
		repeat (2) @(posedge aclk);
		chk_bit("pattern start", 1'b1, combo_out);
		for (k = 1; k < 7; k++) begin
			fire <= 1'b1;
			@(posedge aclk);
			fire <= 1'b0;
			repeat (12) @(posedge aclk);
			chk_bit("pattern bit", img[656 + k % 4], combo_out);
		end
		wr(5'h08, {16'h0, 16'hb5c3}, r);
		// input 1 reads a 1 while the pattern last stood on a 0
		combo_in <= 4'h1;
		repeat (2) @(posedge aclk);
		chk_bit("table again", img[657], combo_out);
		tally_and_finish();
	end
endmodule : lcpg_top_test

`default_nettype wire
